/* pkg/uart_regs_pkg.sv */
package uart_regs_pkg;

  // Register addresses within one channel
  localparam logic [2:0] ADDR_HOLDING = 3'h0;
  localparam logic [2:0] ADDR_INT_ENABLE = 3'h1;
  localparam logic [2:0] ADDR_STATUS_FIFO = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STAT = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STAT = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;

  // Bank selection keys and field positions
  localparam int DIV_ENABLE_BIT = 7;
  localparam int ENHANCED_BIT = 4;
  localparam int FIFO_ENABLE_BIT = 0;
  localparam int RX_FIFO_RESET_BIT = 1;
  localparam int TX_FIFO_RESET_BIT = 2;
  localparam logic [7:0] ENHANCED_KEY = 8'hBF;
  localparam logic [7:0] DIVISOR_ZERO = 8'h00;

  // Fields that only exist while the enhanced bit is set, the fraction width and the FIFO reset pulse bits
  localparam logic [7:0] INT_ENABLE_ENH_MASK = 8'hF0;
  localparam logic [1:0] INT_FLAGS_ENH_MASK = 2'h3;
  localparam logic [7:0] FIFO_CTRL_ENH_MASK = 8'h30;
  localparam logic [7:0] MODEM_CTRL_ENH_MASK = 8'hE0;
  localparam logic [7:0] FRACTION_MASK = 8'h3F;
  localparam logic [7:0] FIFO_PULSE_MASK = 8'h06;

  // Reset value of every stored byte
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [4:0] {
    sel_none, sel_rx_tx, sel_int_enable, sel_status_fifo, sel_line_ctrl,
    sel_modem_ctrl, sel_line_stat, sel_modem_stat, sel_scratch,
    sel_div_low, sel_div_high, sel_div_frac, sel_revision, sel_ident,
    sel_enh_func, sel_xon1, sel_xon2, sel_xoff1, sel_xoff2
  } reg_sel_t;

  // Status that the rest of the channel presents for reading
  typedef struct packed {
    logic [7:0] rx_data;
    logic [7:0] line_status;
    logic [7:0] modem_status;
    logic [1:0] int_flags;
    logic [3:0] int_source;
  } chan_status_t;

  // Stored configuration of one channel
  typedef struct packed {
    logic [7:0] int_enable;
    logic [7:0] fifo_control;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] scratch_pad;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] divisor_fraction;
    logic [7:0] enhanced_function;
    logic [7:0] xon_char_1;
    logic [7:0] xon_char_2;
    logic [7:0] xoff_char_1;
    logic [7:0] xoff_char_2;
  } chan_regs_t;

  // One-cycle side effects of host accesses
  typedef struct packed {
    logic tx_write;
    logic [7:0] tx_data;
    logic rx_read;
    logic line_status_read;
    logic modem_status_read;
    logic tx_fifo_reset;
    logic rx_fifo_reset;
  } chan_events_t;

endpackage

/* src/channel_bank_decode.sv */
`timescale 1ns/1ps
`default_nettype none

// Maps address and bank state of one channel to the register reached
module channel_bank_decode
  import uart_regs_pkg::*;
(
  input wire logic [2:0] address,
  input wire logic is_write,
  input wire logic [7:0] line_control,
  input wire logic [7:0] divisor_low,
  input wire logic [7:0] divisor_high,
  input wire logic enhanced_on,
  output reg_sel_t sel
);

  logic enh_bank;
  logic div_bank;
  logic div_zero;

  // Bank qualifiers
  assign enh_bank = (line_control == ENHANCED_KEY);
  assign div_bank = line_control[DIV_ENABLE_BIT] && !enh_bank;
  assign div_zero = (divisor_low == DIVISOR_ZERO) && (divisor_high == DIVISOR_ZERO);

  // Address decode; the enhanced key value also sets the divisor bit,
  // so it is tested first wherever it overrides a location
  always_comb
  begin
    sel = sel_none;
    unique case (address)
      ADDR_HOLDING:
        if (!line_control[DIV_ENABLE_BIT])
          sel = sel_rx_tx;
        else if (div_bank)
          sel = (!is_write && div_zero) ? sel_revision : sel_div_low;
      ADDR_INT_ENABLE:
        if (!line_control[DIV_ENABLE_BIT])
          sel = sel_int_enable;
        else if (div_bank)
          sel = (!is_write && div_zero) ? sel_ident : sel_div_high;
      ADDR_STATUS_FIFO:
        if (enh_bank)
          sel = sel_enh_func;
        else if (div_bank && enhanced_on)
          sel = sel_div_frac;
        else
          sel = sel_status_fifo;
      ADDR_LINE_CTRL:
        sel = sel_line_ctrl;
      ADDR_MODEM_CTRL:
        sel = enh_bank ? sel_xon1 : sel_modem_ctrl;
      ADDR_LINE_STAT:
        sel = enh_bank ? sel_xon2 : sel_line_stat;
      ADDR_MODEM_STAT:
        sel = enh_bank ? sel_xoff1 : sel_modem_stat;
      ADDR_SCRATCH:
        sel = enh_bank ? sel_xoff2 : sel_scratch;
    endcase
  end

endmodule

`default_nettype wire

/* src/uart_channel_register_decode.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Two channels, each with own registers, picked by its own select.
// - Address 0 with divisor bit clear reads receive data, writes transmit.
// - Divisor bank, not key value: addresses 0 and 1 hold divisor bytes.
// - Fraction at address 2 needs divisor bank and enhanced bit; 7:6 read 0.
// - Divisor zero in divisor bank: address 0 reads a fixed revision.
// - Same condition: address 1 reads a fixed identification code.
// - Interrupt enable at address 1 while divisor bit is clear.
// - Enhanced fields act only with enhanced bit set, else read zero.
// - Address 2 outside key bank and fraction case reads interrupt status, writes FIFO control.
// - FIFO control: triggers, DMA mode, FIFO resets, FIFO enable.
// - Line control at address 3 readable and writable in every bank.
// - Modem control at address 4 with its eight control bits.
// - Line status at address 5 is read-only.
// - Modem status at address 6 shows inputs high, change flags low.
// - Scratch byte at address 7 with no side effect.
// - Key value selects enhanced function register at address 2.
// - Key value maps addresses 4 to 7 to the four flow characters.
module uart_channel_register_decode
  import uart_regs_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h01, // Arbitrary value
  parameter logic [7:0] IDENT = 8'h5A // Arbitrary value
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic channel_a_select_n,
  input wire logic channel_b_select_n,
  input wire logic [2:0] address,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire chan_status_t [1:0] status,
  output chan_regs_t [1:0] config_out,
  output chan_events_t [1:0] events
);

  typedef struct packed {
    chan_regs_t [1:0] regs;
    chan_events_t [1:0] ev;
    logic [7:0] data_out;
    logic data_oe;
    logic write_prev_n;
    logic [1:0] read_prev;
  } state_t;

  state_t st;
  state_t next_st;
  logic [1:0] select;
  logic [1:0] read_now;
  logic [1:0] read_start;
  logic [1:0] write_take;
  reg_sel_t [1:0] sel;
  chan_regs_t [1:0] eff;

  // Clear enhanced fields while the enhanced bit is off; storage keeps
  // the raw value so turning the bit back on restores it
  function automatic chan_regs_t effective(input chan_regs_t r);
    chan_regs_t e;
    e = r;
    e.divisor_fraction = r.divisor_fraction & FRACTION_MASK;
    if (!r.enhanced_function[ENHANCED_BIT])
    begin
      e.int_enable = r.int_enable & ~INT_ENABLE_ENH_MASK;
      e.fifo_control = r.fifo_control & ~FIFO_CTRL_ENH_MASK;
      e.modem_control = r.modem_control & ~MODEM_CTRL_ENH_MASK;
    end
    return e;
  endfunction

  // Read multiplexer for one channel
  function automatic logic [7:0] read_value(
    input reg_sel_t s,
    input chan_regs_t r,
    input chan_status_t x
  );
    logic [1:0] flags;
    logic [7:0] v;
    flags = r.enhanced_function[ENHANCED_BIT] ? x.int_flags : ~INT_FLAGS_ENH_MASK;
    v = REG_RESET;
    unique case (s)
      sel_rx_tx: v = x.rx_data;
      sel_int_enable: v = r.int_enable;
      sel_status_fifo: v = {{2{r.fifo_control[FIFO_ENABLE_BIT]}}, flags,
        x.int_source};
      sel_line_ctrl: v = r.line_control;
      sel_modem_ctrl: v = r.modem_control;
      sel_line_stat: v = x.line_status;
      sel_modem_stat: v = x.modem_status;
      sel_scratch: v = r.scratch_pad;
      sel_div_low: v = r.divisor_low;
      sel_div_high: v = r.divisor_high;
      sel_div_frac: v = r.divisor_fraction;
      sel_revision: v = REVISION;
      sel_ident: v = IDENT;
      sel_enh_func: v = r.enhanced_function;
      sel_xon1: v = r.xon_char_1;
      sel_xon2: v = r.xon_char_2;
      sel_xoff1: v = r.xoff_char_1;
      sel_xoff2: v = r.xoff_char_2;
      sel_none: v = REG_RESET;
    endcase
    return v;
  endfunction

  // Channel strobes; each select sees only its own channel
  assign select = {!channel_b_select_n, !channel_a_select_n};
  assign read_now = select & {2{!read_n}};
  assign read_start = read_now & ~st.read_prev;
  assign write_take = select & {2{!write_n && st.write_prev_n}};

  // One decoder per channel, driven by that channel's own bank state
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    channel_bank_decode u_decode (
      .address(address),
      .is_write(!write_n),
      .line_control(st.regs[c].line_control),
      .divisor_low(st.regs[c].divisor_low),
      .divisor_high(st.regs[c].divisor_high),
      .enhanced_on(st.regs[c].enhanced_function[ENHANCED_BIT]),
      .sel(sel[c])
    );
    assign eff[c] = effective(st.regs[c]);
  end

  // Next-state logic: writes, read capture and side-effect pulses
  always_comb
  begin
    next_st = st;
    next_st.write_prev_n = write_n;
    next_st.read_prev = read_now;
    next_st.data_oe = |read_now;
    for (int c = 0; c < 2; c++)
    begin
      next_st.ev[c] = '0;
      // Read data is caught once at the start of the strobe so that a pop
      // issued by that read cannot change the byte the host is sampling
      if (read_start[c])
      begin
        next_st.data_out = read_value(sel[c], eff[c], status[c]);
        next_st.ev[c].rx_read = (sel[c] == sel_rx_tx);
        next_st.ev[c].line_status_read = (sel[c] == sel_line_stat);
        next_st.ev[c].modem_status_read = (sel[c] == sel_modem_stat);
      end
      if (write_take[c])
      begin
        unique case (sel[c])
          sel_rx_tx:
          begin
            next_st.ev[c].tx_write = 1'b1;
            next_st.ev[c].tx_data = data_in;
          end
          sel_int_enable: next_st.regs[c].int_enable = data_in;
          sel_status_fifo:
          begin
            // Reset bits are pulses, not stored state
            next_st.regs[c].fifo_control = data_in & ~FIFO_PULSE_MASK;
            next_st.ev[c].tx_fifo_reset = data_in[TX_FIFO_RESET_BIT];
            next_st.ev[c].rx_fifo_reset = data_in[RX_FIFO_RESET_BIT];
          end
          sel_line_ctrl: next_st.regs[c].line_control = data_in;
          sel_modem_ctrl: next_st.regs[c].modem_control = data_in;
          sel_scratch: next_st.regs[c].scratch_pad = data_in;
          sel_div_low: next_st.regs[c].divisor_low = data_in;
          sel_div_high: next_st.regs[c].divisor_high = data_in;
          sel_div_frac:
            next_st.regs[c].divisor_fraction = data_in & FRACTION_MASK;
          sel_enh_func: next_st.regs[c].enhanced_function = data_in;
          sel_xon1: next_st.regs[c].xon_char_1 = data_in;
          sel_xon2: next_st.regs[c].xon_char_2 = data_in;
          sel_xoff1: next_st.regs[c].xoff_char_1 = data_in;
          sel_xoff2: next_st.regs[c].xoff_char_2 = data_in;
          // Status and fixed codes ignore writes
          sel_line_stat, sel_modem_stat, sel_revision, sel_ident, sel_none:
            next_st.regs[c] = st.regs[c];
        endcase
      end
    end
    // Both selects low is a host fault; channel A wins the bus
    if (read_start[0])
      next_st.data_out = read_value(sel[0], eff[0], status[0]);
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int c = 0; c < 2; c++)
      begin
        st.regs[c] <= {13{REG_RESET}};
        st.ev[c] <= '0;
      end
      st.data_out <= REG_RESET;
      st.data_oe <= 1'b0;
      st.write_prev_n <= 1'b1;
      st.read_prev <= 2'b00;
    end
    else
      st <= next_st;
  end

  // Outputs
  assign data_out = st.data_out;
  assign data_oe = st.data_oe;
  assign config_out = eff;
  assign events = st.ev;

  // Checks on channel A
  property p_tx_load;
    @(posedge clk) disable iff (!reset_n)
    write_take[0] && sel[0] == sel_rx_tx
      |=> events[0].tx_write && events[0].tx_data == $past(data_in);
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("transmit load pulse or data wrong");

  property p_rx_read;
    @(posedge clk) disable iff (!reset_n)
    read_start[0] && sel[0] == sel_rx_tx
      |=> data_out == $past(status[0].rx_data) && events[0].rx_read && data_oe;
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("receive byte not returned");

  property p_div_low;
    @(posedge clk) disable iff (!reset_n)
    write_take[0] && address == ADDR_HOLDING && st.regs[0].line_control[DIV_ENABLE_BIT]
      && st.regs[0].line_control != ENHANCED_KEY
      |=> config_out[0].divisor_low == $past(data_in) && !events[0].tx_write;
  endproperty
  a_div_low: assert property (p_div_low)
    else $error("divisor low byte not stored");

  property p_frac_top;
    @(posedge clk) disable iff (!reset_n)
    read_start[0] && sel[0] == sel_div_frac |=> data_out[7:6] == 2'b00;
  endproperty
  a_frac_top: assert property (p_frac_top)
    else $error("fraction top bits not zero");

  property p_revision;
    @(posedge clk) disable iff (!reset_n)
    read_start[0] && !read_start[1] && address == ADDR_HOLDING
      && st.regs[0].line_control[DIV_ENABLE_BIT]
      && st.regs[0].line_control != ENHANCED_KEY
      && st.regs[0].divisor_low == DIVISOR_ZERO && st.regs[0].divisor_high == DIVISOR_ZERO
      |=> data_out == REVISION;
  endproperty
  a_revision: assert property (p_revision)
    else $error("revision code not returned");

  property p_ident;
    @(posedge clk) disable iff (!reset_n)
    read_start[0] && sel[0] == sel_ident ##1 1'b1 |-> data_out == IDENT;
  endproperty
  a_ident: assert property (p_ident)
    else $error("identification code not returned");

  property p_enh_mask;
    @(posedge clk) disable iff (!reset_n)
    !config_out[0].enhanced_function[ENHANCED_BIT]
      |-> config_out[0].int_enable[7:4] == 4'h0 && config_out[0].modem_control[7:5] == 3'h0
      && config_out[0].fifo_control[5:4] == 2'h0;
  endproperty
  a_enh_mask: assert property (p_enh_mask)
    else $error("enhanced field visible while disabled");

  property p_line_ctrl;
    @(posedge clk) disable iff (!reset_n)
    write_take[0] && address == ADDR_LINE_CTRL
      |=> config_out[0].line_control == $past(data_in);
  endproperty
  a_line_ctrl: assert property (p_line_ctrl)
    else $error("line control not written");

  property p_scratch_hold;
    @(posedge clk) disable iff (!reset_n)
    !(write_take[0] && sel[0] == sel_scratch) |=> $stable(config_out[0].scratch_pad);
  endproperty
  a_scratch_hold: assert property (p_scratch_hold)
    else $error("scratch byte changed without a write");

  property p_xoff2;
    @(posedge clk) disable iff (!reset_n)
    write_take[0] && address == ADDR_SCRATCH && st.regs[0].line_control == ENHANCED_KEY
      |=> config_out[0].xoff_char_2 == $past(data_in)
      && $stable(config_out[0].scratch_pad);
  endproperty
  a_xoff2: assert property (p_xoff2)
    else $error("flow character not written in key bank");

  // Checks on stored state, FIFO reset pulses and read paths; the write antecedents use the address
  // and bank bits directly so a wrong decoder entry cannot hide itself; the read ones use sel
  property p_chan_b_hold;
    @(posedge clk) disable iff (!reset_n)
    !write_take[1] |=> $stable(st.regs[1]);
  endproperty
  a_chan_b_hold: assert property (p_chan_b_hold)
    else $error("channel B changed without its own write");

  property p_int_enable;
    @(posedge clk) disable iff (!reset_n)
    write_take[0] && address == ADDR_INT_ENABLE && !st.regs[0].line_control[DIV_ENABLE_BIT]
      |=> st.regs[0].int_enable == $past(data_in);
  endproperty
  a_int_enable: assert property (p_int_enable)
    else $error("interrupt enable not stored");

  property p_fifo_pulse;
    @(posedge clk) disable iff (!reset_n)
    write_take[0] && address == ADDR_STATUS_FIFO && st.regs[0].line_control != ENHANCED_KEY
      && !(st.regs[0].line_control[DIV_ENABLE_BIT]
      && st.regs[0].enhanced_function[ENHANCED_BIT])
      |=> events[0].tx_fifo_reset == $past(data_in[TX_FIFO_RESET_BIT])
      && events[0].rx_fifo_reset == $past(data_in[RX_FIFO_RESET_BIT]);
  endproperty
  a_fifo_pulse: assert property (p_fifo_pulse)
    else $error("FIFO reset pulses wrong");

  property p_status_read;
    @(posedge clk) disable iff (!reset_n)
    read_start[0] && sel[0] == sel_status_fifo
      |=> data_out[3:0] == $past(status[0].int_source)
      && data_out[7] == $past(st.regs[0].fifo_control[FIFO_ENABLE_BIT])
      && data_out[6] == data_out[7];
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("interrupt status byte wrong");

  property p_line_stat_read;
    @(posedge clk) disable iff (!reset_n)
    read_start[0] && sel[0] == sel_line_stat
      |=> data_out == $past(status[0].line_status) && events[0].line_status_read;
  endproperty
  a_line_stat_read: assert property (p_line_stat_read)
    else $error("line status not returned");

  property p_enh_func;
    @(posedge clk) disable iff (!reset_n)
    write_take[0] && address == ADDR_STATUS_FIFO && st.regs[0].line_control == ENHANCED_KEY
      |=> st.regs[0].enhanced_function == $past(data_in);
  endproperty
  a_enh_func: assert property (p_enh_func)
    else $error("enhanced function byte not stored");

endmodule

`default_nettype wire

/* verification/host_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host processor on the parallel register bus, one byte per access
module host_bus_model
(
  input wire logic clk,
  output logic channel_a_select_n,
  output logic channel_b_select_n,
  output logic [2:0] address,
  output logic read_n,
  output logic write_n,
  output logic [7:0] data_in
);
  // Idle bus at time zero; nothing selected
  initial
  begin
    channel_a_select_n = 1'b1;
    channel_b_select_n = 1'b1;
    address = 3'h0;
    read_n = 1'b1;
    write_n = 1'b1;
    data_in = 8'h00;
  end

  // Strobe held over two edges, so the take edge and the answer edge both see it
  task automatic access(input int ch, input logic wr, input logic [2:0] a,
                        input logic [7:0] d);
    @(posedge clk);
    channel_a_select_n <= (ch != 0);
    channel_b_select_n <= (ch != 1);
    address <= a;
    data_in <= d;
    write_n <= !wr;
    read_n <= wr;
    @(posedge clk);
    @(posedge clk);
    // Released data lines flip, so a stale byte can never pass for a fresh one
    channel_a_select_n <= 1'b1;
    channel_b_select_n <= 1'b1;
    write_n <= 1'b1;
    read_n <= 1'b1;
    data_in <= ~d;
    #1;
  endtask
endmodule

`default_nettype wire

/* verification/uart_channel_register_decode_test.sv */
`timescale 1ns/1ps
`default_nettype none

module uart_channel_register_decode_test
  import uart_regs_pkg::*;
;
  localparam logic [7:0] REV = 8'h3E; // Arbitrary value
  localparam logic [7:0] IDV = 8'h6C; // Arbitrary value
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  wire logic cs_a_n;
  wire logic cs_b_n;
  wire logic [2:0] addr;
  wire logic rd_n;
  wire logic wr_n;
  wire logic [7:0] din;
  logic [7:0] dout;
  logic oe;
  chan_status_t [1:0] status;
  chan_regs_t [1:0] cfg;
  chan_events_t [1:0] events;
  chan_events_t seen [2];
  int error_cnt = 0;
  int samples_checked = 0;

  always #20 clk = ~clk;

  host_bus_model host (.clk(clk), .channel_a_select_n(cs_a_n), .channel_b_select_n(cs_b_n),
    .address(addr), .read_n(rd_n), .write_n(wr_n), .data_in(din));

  uart_channel_register_decode #(.REVISION(REV), .IDENT(IDV)) DUT (.clk(clk),
    .reset_n(reset_n), .channel_a_select_n(cs_a_n), .channel_b_select_n(cs_b_n),
    .address(addr), .read_n(rd_n), .write_n(wr_n), .data_in(din), .data_out(dout),
    .data_oe(oe), .status(status), .config_out(cfg), .events(events));

  // Pulses last one cycle, so they are gathered until a scenario looks
  always @(posedge clk)
  begin
    seen[0] <= seen[0] | events[0];
    seen[1] <= seen[1] | events[1];
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input int ch, input logic [2:0] a, input logic [7:0] d);
    host.access(ch, 1'b1, a, d);
  endtask

  task automatic rd_chk(input string what, input int ch, input logic [2:0] a,
                        input logic [7:0] exp);
    host.access(ch, 1'b0, a, 8'h00);
    chk8(what, exp, dout);
  endtask

  task automatic clr();
    seen[0] = '0;
    seen[1] = '0;
  endtask

  task automatic t_reset();
    chk1("oe_reset", 1'b0, oe);
    chk8("lcr_a_reset", 8'h00, cfg[0].line_control);
    rd_chk("spr_b_reset", 1, 3'h7, 8'h00);
  endtask

  task automatic t_normal();
    clr();
    wr(0, 3'h0, 8'h5A);
    chk1("tx_write", 1'b1, seen[0].tx_write);
    chk8("tx_data", 8'h5A, seen[0].tx_data);
    chk1("tx_write_b", 1'b0, seen[1].tx_write);
    rd_chk("rx", 0, 3'h0, 8'hA5);
    chk1("rx_read", 1'b1, seen[0].rx_read);
    chk1("oe_on", 1'b1, oe);
    @(posedge clk);
    #1;
    chk1("oe_off", 1'b0, oe);
  endtask

  task automatic t_enh();
    wr(0, 3'h1, 8'hFF);
    chk8("ier_cfg", 8'h0F, cfg[0].int_enable);
    rd_chk("ier_plain", 0, 3'h1, 8'h0F);
    wr(0, 3'h4, 8'hFF);
    rd_chk("mcr_plain", 0, 3'h4, 8'h1F);
    wr(0, 3'h3, 8'hBF);
    rd_chk("lcr_key", 0, 3'h3, 8'hBF);
    wr(0, 3'h2, 8'h10);
    rd_chk("efr", 0, 3'h2, 8'h10);
    wr(0, 3'h3, 8'h00);
    rd_chk("ier_enh", 0, 3'h1, 8'hFF);
    rd_chk("mcr_enh", 0, 3'h4, 8'hFF);
  endtask

  task automatic t_div();
    wr(0, 3'h3, 8'h80);
    rd_chk("revision", 0, 3'h0, REV);
    rd_chk("ident", 0, 3'h1, IDV);
    wr(0, 3'h0, 8'h34);
    wr(0, 3'h1, 8'h12);
    rd_chk("div_low", 0, 3'h0, 8'h34);
    rd_chk("div_high", 0, 3'h1, 8'h12);
    wr(0, 3'h2, 8'hFF);
    rd_chk("fraction", 0, 3'h2, 8'h3F);
    rd_chk("lcr_div", 0, 3'h3, 8'h80);
  endtask

  task automatic t_stat();
    chan_regs_t keep;
    wr(0, 3'h3, 8'h03);
    clr();
    wr(0, 3'h2, 8'hF7);
    chk1("tx_fifo_rst", 1'b1, seen[0].tx_fifo_reset);
    chk1("rx_fifo_rst", 1'b1, seen[0].rx_fifo_reset);
    chk8("fcr_cfg", 8'hF1, cfg[0].fifo_control);
    rd_chk("isr_enh", 0, 3'h2, 8'hF1);
    chk8("fcr_kept", 8'hF1, cfg[0].fifo_control);
    rd_chk("lsr", 0, 3'h5, 8'h61);
    chk1("lsr_read", 1'b1, seen[0].line_status_read);
    rd_chk("msr", 0, 3'h6, 8'hB4);
    chk1("msr_read", 1'b1, seen[0].modem_status_read);
    keep = cfg[0];
    wr(0, 3'h5, 8'hFF);
    wr(0, 3'h6, 8'hFF);
    chk1("ro_write", 1'b1, cfg[0] === keep);
    clr();
    wr(0, 3'h7, 8'hC3);
    rd_chk("spr", 0, 3'h7, 8'hC3);
    chk1("spr_quiet", 1'b1, seen[0] === '0);
    wr(0, 3'h3, 8'hBF);
    wr(0, 3'h2, 8'h00);
    wr(0, 3'h3, 8'h03);
    rd_chk("isr_plain", 0, 3'h2, 8'hC1);
    chk8("fcr_plain", 8'hC1, cfg[0].fifo_control);
  endtask

  task automatic t_flow();
    wr(0, 3'h3, 8'hBF);
    rd_chk("unmapped", 0, 3'h0, 8'h00);
    for (int i = 0; i < 4; i++)
      wr(0, 3'(4 + i), 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 4; i++)
      rd_chk("flow_char", 0, 3'(4 + i), 8'(8'h11 * (i + 1)));
    chk8("xoff2_cfg", 8'h44, cfg[0].xoff_char_2);
    wr(0, 3'h3, 8'h03);
    rd_chk("mcr_back", 0, 3'h4, 8'h1F);
  endtask

  task automatic t_chan();
    wr(1, 3'h7, 8'h3C);
    rd_chk("spr_b", 1, 3'h7, 8'h3C);
    rd_chk("spr_a", 0, 3'h7, 8'hC3);
    rd_chk("rx_b", 1, 3'h0, 8'h5E);
    rd_chk("lcr_b", 1, 3'h3, 8'h00);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // About 160 cycles of traffic; the limit of 5000 cycles leaves wide margin
  initial
  begin
    #200000;
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    status[0] <= {8'hA5, 8'h61, 8'hB4, 2'h3, 4'h1};
    status[1] <= {8'h5E, 8'h20, 8'h00, 2'h0, 4'h1};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_normal();
    t_enh();
    t_div();
    t_stat();
    t_flow();
    t_chan();
    give_verdict();
  end
endmodule

`default_nettype wire
